// file: rtl/small_ram_pkg.sv
// Shared constants and mode encoding for the small dual-clock RAM
`default_nettype none
package small_ram_pkg;
    localparam int TOTAL_BITS = 576;
    localparam int DATA_W = 18;
    localparam int DEPTH = TOTAL_BITS / DATA_W;
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int COUNT_W = ADDR_W + 1;
    localparam logic [DATA_W-1:0] OUT_RESET = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 6'h00;
    localparam logic [COUNT_W-1:0] COUNT_FULL = 6'h20;

    typedef enum logic [2:0] {
        MODE_SIMPLE_DUAL = 3'b000,
        MODE_SINGLE = 3'b001,
        MODE_FIFO = 3'b010,
        MODE_ROM = 3'b011,
        MODE_SHIFT = 3'b100
    } mode_t;

    function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] ptr);
        return (ptr == ADDR_W'(DEPTH - 1)) ? ADDR_RESET : ADDR_W'(ptr + 1'b1);
    endfunction
endpackage
`default_nettype wire

// file: rtl/ram_port_if.sv
// Signals between the control logic and the storage array
`timescale 1ns/1ps
`default_nettype none
interface ram_port_if;
    logic wr_stb;
    logic [small_ram_pkg::ADDR_W-1:0] wr_addr;
    logic [small_ram_pkg::DATA_W-1:0] wr_data;
    logic rd_stb;
    logic [small_ram_pkg::ADDR_W-1:0] rd_addr;
    logic [small_ram_pkg::DATA_W-1:0] rd_data;

    modport ctrl (output wr_stb, wr_addr, wr_data, rd_stb, rd_addr, input rd_data);
    modport store (input wr_stb, wr_addr, wr_data, rd_stb, rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: rtl/small_ram_array.sv
// Storage array of 32 words with preload image and synchronous read
`timescale 1ns/1ps
`default_nettype none
module small_ram_array #(
    parameter logic [small_ram_pkg::TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
    input wire logic sys_clk,
    ram_port_if.store port
);
    typedef logic [small_ram_pkg::DATA_W-1:0] word_arr_t [small_ram_pkg::DEPTH];

    // Preload from a constant image; word 0 sits in the low bits
    function automatic word_arr_t unpack_image(input logic [small_ram_pkg::TOTAL_BITS-1:0] img);
        word_arr_t words;
        for (int i = 0; i < small_ram_pkg::DEPTH; i++) begin
            words[i] = img[i*small_ram_pkg::DATA_W +: small_ram_pkg::DATA_W];
        end
        return words;
    endfunction

    // Set at declaration so the write process stays its only driver
    word_arr_t mem = unpack_image(INIT_IMAGE);

    always_ff @(posedge sys_clk) begin
        if (port.wr_stb) begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    // Same-address collision returns the old word
    always_ff @(posedge sys_clk) begin
        if (port.rd_stb) begin
            port.rd_data <= mem[port.rd_addr];
        end
    end
endmodule
`default_nettype wire

// file: rtl/dual_clock_small_ram.sv
// Small embedded RAM with selectable clocks, modes and output register
//
// How it works
// - Array holds 576 bits, parity included, as 32 words of 18 bits.
// - Modes: simple dual-port, single-port, FIFO, ROM, shift register; no true dual-port.
// - RAM and ROM contents preload from a constant image before operation.
// - Write enable, data and address registers share one selected clock.
// - Read address, read enable and output registers each pick either clock.
// - Only the output data register can be bypassed.
// - Input clear resets input registers at once; no read starts, so output keeps its value.
// - Output clear resets output register at once; visible only when it is not bypassed.
`timescale 1ns/1ps
`default_nettype none
module dual_clock_small_ram #(
    parameter logic [small_ram_pkg::TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en_0,
    input wire logic clk_en_1,
    input wire logic wr_clk_sel,
    input wire logic rd_addr_clk_sel,
    input wire logic rd_en_clk_sel,
    input wire logic out_clk_sel,
    input wire logic out_reg_bypass,
    input wire logic [2:0] mode,
    input wire logic in_clr,
    input wire logic out_clr,
    input wire logic wr_en,
    input wire logic [small_ram_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [small_ram_pkg::DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [small_ram_pkg::ADDR_W-1:0] rd_addr,
    output logic [small_ram_pkg::DATA_W-1:0] rd_data,
    output logic fifo_full,
    output logic fifo_empty
);
    ram_port_if port ();

    small_ram_array #(.INIT_IMAGE(INIT_IMAGE)) u_array (
        .sys_clk(sys_clk),
        .port(port)
    );

    // One chooser for every register group, so all selects decode alike
    function automatic logic pick_ce(input logic sel, input logic ce0, input logic ce1);
        return sel ? ce1 : ce0;
    endfunction

    // The two block clocks are enable pulses on sys_clk
    logic wr_ce;
    logic rd_addr_ce;
    logic rd_en_ce;
    logic out_ce;
    assign wr_ce = pick_ce(wr_clk_sel, clk_en_0, clk_en_1);
    assign rd_addr_ce = pick_ce(rd_addr_clk_sel, clk_en_0, clk_en_1);
    assign rd_en_ce = pick_ce(rd_en_clk_sel, clk_en_0, clk_en_1);
    assign out_ce = pick_ce(out_clk_sel, clk_en_0, clk_en_1);

    small_ram_pkg::mode_t cur_mode;
    logic fifo_mode;
    assign cur_mode = small_ram_pkg::mode_t'(mode);
    assign fifo_mode = (cur_mode == small_ram_pkg::MODE_FIFO);

    // Input registers, all in path; input clear acts without the clock
    logic wr_en_q;
    logic [small_ram_pkg::ADDR_W-1:0] wr_addr_q;
    logic [small_ram_pkg::DATA_W-1:0] wr_data_q;
    logic wr_go;
    always_ff @(posedge sys_clk or negedge rstn or posedge in_clr) begin
        if (!rstn || in_clr) begin
            wr_en_q <= 1'b0;
            wr_addr_q <= small_ram_pkg::ADDR_RESET;
            wr_data_q <= small_ram_pkg::OUT_RESET;
            wr_go <= 1'b0;
        end else begin
            wr_go <= wr_ce;
            if (wr_ce) begin
                wr_en_q <= wr_en;
                wr_addr_q <= wr_addr;
                wr_data_q <= wr_data;
            end
        end
    end

    // Read address and read enable may follow different clocks
    logic [small_ram_pkg::ADDR_W-1:0] rd_addr_q;
    logic rd_en_q;
    logic rd_go;
    always_ff @(posedge sys_clk or negedge rstn or posedge in_clr) begin
        if (!rstn || in_clr) begin
            rd_addr_q <= small_ram_pkg::ADDR_RESET;
            rd_en_q <= 1'b0;
            rd_go <= 1'b0;
        end else begin
            rd_go <= rd_addr_ce;
            if (rd_addr_ce) begin
                rd_addr_q <= rd_addr;
            end
            if (rd_en_ce) begin
                rd_en_q <= rd_en;
            end
        end
    end

    // Mode steering of the array strobes and addresses
    logic [small_ram_pkg::ADDR_W-1:0] wr_ptr;
    logic [small_ram_pkg::ADDR_W-1:0] rd_ptr;
    logic [small_ram_pkg::COUNT_W-1:0] fill;
    logic [small_ram_pkg::COUNT_W-1:0] next_fill;
    logic fifo_push;
    logic fifo_pop;
    logic do_write;
    logic do_read;

    always_comb begin
        do_write = 1'b0;
        do_read = 1'b0;
        port.wr_addr = wr_addr_q;
        port.rd_addr = rd_addr_q;
        case (cur_mode)
            small_ram_pkg::MODE_SIMPLE_DUAL: begin
                do_write = wr_go && wr_en_q;
                do_read = rd_go && rd_en_q;
            end
            small_ram_pkg::MODE_SINGLE: begin
                do_write = wr_go && wr_en_q;
                // One address serves both directions
                do_read = rd_go && rd_en_q;
                port.rd_addr = wr_addr_q;
            end
            small_ram_pkg::MODE_FIFO: begin
                // Overflow and underflow are dropped, never wrap the pointers
                do_write = wr_go && wr_en_q && !fifo_full;
                do_read = rd_go && rd_en_q && !fifo_empty;
                port.wr_addr = wr_ptr;
                port.rd_addr = rd_ptr;
            end
            small_ram_pkg::MODE_ROM: begin
                // Writes refused so the preloaded image survives
                do_read = rd_go && rd_en_q;
            end
            small_ram_pkg::MODE_SHIFT: begin
                // Each shift reads the oldest word before overwriting it
                do_write = wr_go && wr_en_q;
                do_read = wr_go && wr_en_q;
                port.wr_addr = wr_ptr;
                port.rd_addr = wr_ptr;
            end
            // Unused codes leave the array alone
            default: begin
                do_write = 1'b0;
                do_read = 1'b0;
            end
        endcase
    end

    assign port.wr_stb = do_write;
    assign port.wr_data = wr_data_q;
    assign port.rd_stb = do_read;

    assign fifo_push = fifo_mode && do_write && !do_read;
    assign fifo_pop = fifo_mode && do_read && !do_write;

    // The count moves only in FIFO mode, so other modes cannot disturb the flags
    always_comb begin
        next_fill = fill;
        if (fifo_push) begin
            next_fill = small_ram_pkg::COUNT_W'(fill + 1'b1);
        end else if (fifo_pop) begin
            next_fill = small_ram_pkg::COUNT_W'(fill - 1'b1);
        end
    end

    // FIFO and shift share the write pointer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= small_ram_pkg::ADDR_RESET;
            rd_ptr <= small_ram_pkg::ADDR_RESET;
            fill <= small_ram_pkg::COUNT_RESET;
        end else begin
            if (do_write && (fifo_mode || cur_mode == small_ram_pkg::MODE_SHIFT)) begin
                wr_ptr <= small_ram_pkg::next_ptr(wr_ptr);
            end
            if (do_read && fifo_mode) begin
                rd_ptr <= small_ram_pkg::next_ptr(rd_ptr);
            end
            fill <= next_fill;
        end
    end

    // Flags track the count they will hold, so a pop at full frees a slot at once
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fifo_full <= 1'b0;
        end else begin
            fifo_full <= (next_fill == small_ram_pkg::COUNT_FULL);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fifo_empty <= 1'b1;
        end else begin
            fifo_empty <= (next_fill == small_ram_pkg::COUNT_RESET);
        end
    end

    // Output register; cleared at power-up and by its own clear
    logic [small_ram_pkg::DATA_W-1:0] out_q;
    always_ff @(posedge sys_clk or negedge rstn or posedge out_clr) begin
        if (!rstn || out_clr) begin
            out_q <= small_ram_pkg::OUT_RESET;
        end else if (out_ce) begin
            out_q <= port.rd_data;
        end
    end

    // Bypass trades a cycle of latency for a mux after the flop
    assign rd_data = out_reg_bypass ? port.rd_data : out_q;
endmodule
`default_nettype wire

// file: test/user_logic_model.sv
// Behavioural user logic that strobes the RAM's ports
`timescale 1ns/1ps
`default_nettype none
module user_logic_model (
    input wire logic sys_clk,
    output logic clk_en_0,
    output logic clk_en_1,
    output logic wr_en,
    output logic [small_ram_pkg::ADDR_W-1:0] wr_addr,
    output logic [small_ram_pkg::DATA_W-1:0] wr_data,
    output logic rd_en,
    output logic [small_ram_pkg::ADDR_W-1:0] rd_addr
);
    initial {clk_en_0, clk_en_1, wr_en, rd_en, wr_addr, wr_data, rd_addr} = '0;
    // One enable pulse per transfer on the chosen clock
    task automatic xfer(input logic s, we, input logic [4:0] wa, input logic [17:0] wd, input logic re);
        @(negedge sys_clk);
        {clk_en_1, clk_en_0} <= s ? 2'b10 : 2'b01;
        {wr_en, wr_addr, wr_data, rd_en, rd_addr} <= {we, wa, wd, re, wa};
        @(negedge sys_clk);
        {clk_en_1, clk_en_0} <= 2'b00;
        // Released enables drop and the other lines flip so a stale value cannot pass
        {wr_en, rd_en, wr_addr, wr_data, rd_addr} <= {2'b00, ~wa, ~wd, ~wa};
    endtask
endmodule
`default_nettype wire

// file: test/small_ram_checker.sv
// Port assertions for the small dual-clock RAM
`timescale 1ns/1ps
`default_nettype none
module small_ram_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en_0,
    input wire logic clk_en_1,
    input wire logic out_clk_sel,
    input wire logic out_reg_bypass,
    input wire logic [2:0] mode,
    input wire logic in_clr,
    input wire logic out_clr,
    input wire logic [small_ram_pkg::DATA_W-1:0] rd_data,
    input wire logic fifo_full,
    input wire logic fifo_empty
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic opulse;
    assign opulse = out_clk_sel ? clk_en_1 : clk_en_0;
    out_clr_zero_a: assert property (out_clr && !out_reg_bypass |-> rd_data == '0)
        else $error("output clear left data");
    clr_stays_a: assert property (out_clr && !out_reg_bypass && !opulse ##1 !out_reg_bypass |-> rd_data == '0)
        else $error("cleared output changed without pulse");
    reset_flags_a: assert property ($rose(rstn) |-> fifo_empty && !fifo_full)
        else $error("flags wrong after reset");
    reset_out_a: assert property ($rose(rstn) && !out_reg_bypass |-> rd_data == '0)
        else $error("output not zero after reset");
    out_hold_a: assert property (!out_reg_bypass && !out_clr && !opulse |=> out_reg_bypass || out_clr || $stable(rd_data))
        else $error("output register moved without its pulse");
    in_clr_hold_a: assert property (in_clr && out_reg_bypass ##1 in_clr && out_reg_bypass |-> $stable(rd_data))
        else $error("read went on under input clear");
    flags_excl_a: assert property (!(fifo_full && fifo_empty))
        else $error("full and empty together");
    flags_quiet_a: assert property ((!clk_en_0 && !clk_en_1 && $stable(mode))[*4] |=> $stable({fifo_full, fifo_empty}))
        else $error("flags moved with no traffic");
    cover property (out_clr && rd_data == '0);
    cover property (fifo_full);
    cover property (out_reg_bypass && rd_data != '0);
endmodule
bind dual_clock_small_ram small_ram_checker u_chk (.sys_clk, .rstn, .clk_en_0, .clk_en_1, .out_clk_sel,
    .out_reg_bypass, .mode, .in_clr, .out_clr, .rd_data, .fifo_full, .fifo_empty);
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the small dual-clock RAM
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int W = small_ram_pkg::DATA_W;
    function automatic logic [small_ram_pkg::TOTAL_BITS-1:0] image();
        for (int i = 0; i < 32; i++) image[W*i +: W] = W'(i * 3 + 5);
    endfunction
    logic sys_clk = 0, rstn = 0, wr_clk_sel = 0, rd_sel = 0, out_reg_bypass = 0, in_clr = 0, out_clr = 0;
    logic [2:0] mode = 3'h0;
    logic clk_en_0, clk_en_1, wr_en, rd_en, fifo_full, fifo_empty;
    logic [small_ram_pkg::ADDR_W-1:0] wr_addr, rd_addr;
    logic [W-1:0] wr_data, rd_data;
    int error_cnt = 0, n_compared = 0;
    always #4 sys_clk = ~sys_clk;
    user_logic_model u_user (.sys_clk, .clk_en_0, .clk_en_1, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr);
    dual_clock_small_ram #(.INIT_IMAGE(image())) u_dut (.sys_clk, .rstn, .clk_en_0, .clk_en_1, .wr_clk_sel,
        .rd_addr_clk_sel(rd_sel), .rd_en_clk_sel(rd_sel), .out_clk_sel(rd_sel), .out_reg_bypass, .mode,
        .in_clr, .out_clr, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data, .fifo_full, .fifo_empty);
    task automatic check(input logic [W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic s, input logic [4:0] a, input logic [W-1:0] d);
        u_user.xfer(s, 1'b1, a, d, 1'b0);
    endtask
    // Read pulse, a cycle for the array, then an output pulse unless bypassed
    task automatic rd(input logic s, input logic [4:0] a, input logic [W-1:0] exp);
        rd_sel = s;
        u_user.xfer(s, 1'b0, a, '0, 1'b1);
        @(negedge sys_clk);
        if (!out_reg_bypass) u_user.xfer(s, 1'b0, a, '0, 1'b0);
        check(rd_data, exp);
    endtask
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) rstn = 1;
        check(rd_data, '0);
        check(W'({fifo_full, fifo_empty}), 18'h1);
        mode = 3'h3;
        rd(0, 5'h07, 18'h0001A);
        wr(0, 5'h07, 18'h3FFFF);
        rd(1, 5'h07, 18'h0001A);
        mode = 3'h2;
        // The 33rd push must be dropped, else slot 0 is overwritten
        for (int i = 0; i < 33; i++) wr(0, 5'(i), 18'(i + 'h100));
        repeat (2) @(negedge sys_clk);
        check(W'({fifo_full, fifo_empty}), 18'h2);
        for (int i = 0; i < 32; i++) rd(0, 5'h00, 18'(i + 'h100));
        repeat (2) @(negedge sys_clk);
        check(W'({fifo_full, fifo_empty}), 18'h1);
        // Shift mode: each push hands back the word it displaces, 32 deep
        mode = 3'h4;
        out_reg_bypass = 1;
        for (int i = 0; i < 33; i++) begin
            wr(0, 5'h00, 18'(i + 'h200));
            @(negedge sys_clk);
            check(rd_data, (i < 32) ? 18'(i + 'h100) : 18'h00200);
        end
        out_reg_bypass = 0;
        mode = 3'h0;
        wr_clk_sel = 1;
        wr(1, 5'h05, 18'h2ABCD);
        wr(0, 5'h05, 18'h11111);
        rd(0, 5'h05, 18'h2ABCD);
        out_reg_bypass = 1;
        rd(1, 5'h07, 18'h00207);
        // Under input clear a pulsed write and read must both be lost
        in_clr = 1;
        u_user.xfer(1, 1'b1, 5'h03, 18'h3FFFF, 1'b1);
        repeat (2) @(negedge sys_clk);
        check(rd_data, 18'h00207);
        {in_clr, out_reg_bypass, wr_clk_sel} = 3'b000;
        rd(0, 5'h03, 18'h00203);
        mode = 3'h1;
        wr(0, 5'h09, 18'h15A5A);
        rd(0, 5'h09, 18'h15A5A);
        @(negedge sys_clk) out_clr = 1;
        #1 check(rd_data, '0);
        @(negedge sys_clk) out_clr = 0;
        repeat (2) @(negedge sys_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
